// ===== ipc_assertions.sv
// Checker: port level assertions for the pin config block
`timescale 1ns/1ps
`default_nettype none
module ipc_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        boot_strap_select,
	input wire logic        events_pin_a,
	input wire logic        data_ready_event,
	input wire logic        decimation_cycles_done,
	input wire logic        acquire_start,
	input wire logic        irq_pin_a_out,
	input wire logic        irq_pin_a_oe_n,
	input wire logic        irq_pin_b_oe_n,
	input wire logic        irq_pin_b_in
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************************************
	// Shadow of the config register; pins lag it by one cycle
	// ****************************************************************
	logic [7:0] cfg;
	logic [7:0] cfg_q;
	logic       st_q;
	logic       ev_q;
	logic       arm;
	logic [12:0] pc;
	// Pin A is active for a routed event or a ready pulse
	wire        act = events_pin_a || pc != 13'h0;
	wire        wr = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= 8'h01;
			cfg_q <= 8'h01;
			st_q <= 1'b0;
			ev_q <= 1'b0;
			arm <= 1'b0;
			pc <= 13'h0;
		end else begin
			if (wr && paddr == 8'h18)
				cfg <= pwdata[7:0];
			else if (wr && paddr == 8'h1c)
				cfg <= pwdata[1] ? 8'h01 : (pwdata[0] ? cfg & 8'h03 : cfg);
			cfg_q <= cfg;
			st_q <= boot_strap_select;
			if (data_ready_event && cfg[3] && !boot_strap_select)
				pc <= 13'(ipc_pkg::PULSE_CYCLES);
			else if (pc != 13'h0)
				pc <= pc - 13'h1;
			ev_q <= act;
			arm <= 1'b1;
		end
	end
	sequence s_edge;
		!boot_strap_select && cfg[2] && $rose(irq_pin_b_in) && !acquire_start;
	endsequence
	a_pin_level: assert property (
		arm && !st_q && (!cfg_q[1] || ev_q)
		|-> irq_pin_a_out == (ev_q ~^ cfg_q[0]))
		else $error("pin A level wrong");
	a_push_pull: assert property (
		arm && !st_q && !cfg_q[1] |-> !irq_pin_a_oe_n)
		else $error("push-pull not driven");
	a_open_release: assert property (
		arm && !st_q && cfg_q[1] |-> irq_pin_a_oe_n == !ev_q)
		else $error("open pin drive wrong");
	a_strap_fixed: assert property (
		arm && st_q |-> (irq_pin_a_oe_n || !irq_pin_a_out)
		&& irq_pin_a_oe_n == !ev_q)
		else $error("strap drive wrong");
	a_trig_hiz: assert property (
		arm && !st_q && cfg_q[2] |-> irq_pin_b_oe_n)
		else $error("pin B driven");
	a_trig_start: assert property (
		s_edge |-> ##[2:4] acquire_start)
		else $error("no acquire start");
	a_full_hold: assert property (
		acquire_start && cfg[7] && !decimation_cycles_done
		|=> acquire_start)
		else $error("full request dropped");
	a_single_once: assert property (
		acquire_start && !cfg[7] |=> !acquire_start)
		else $error("single held");
endmodule
bind ipc_top ipc_checker u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .boot_strap_select,
	.events_pin_a, .data_ready_event, .decimation_cycles_done,
	.acquire_start, .irq_pin_a_out, .irq_pin_a_oe_n, .irq_pin_b_oe_n,
	.irq_pin_b_in);
`default_nettype wire

// ===== ipc_host.sv
// Host side model: pull resistors and trigger drive on the pins
`timescale 1ns/1ps
`default_nettype none
module ipc_host (
	input  wire logic pin_a_out,
	input  wire logic pin_a_oe_n,
	input  wire logic pin_b_out,
	input  wire logic pin_b_oe_n,
	input  wire logic pull_up,
	input  wire logic trig_level,
	output logic      pin_a,
	output logic      pin_b
);
	// Released pin A settles to the pull resistor, not the last value
	assign pin_a = pin_a_oe_n ? pull_up : pin_a_out;
	assign pin_b = pin_b_oe_n ? trig_level : pin_b_out;
endmodule
`default_nettype wire

// ===== ipc_pkg.sv
// Package: register map, field layout and timing constants for pin config
package ipc_pkg;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFF_PIN_CONFIG  = 8'h18;
	localparam logic [7:0] OFF_EXTRA       = 8'h1c;
	localparam logic [7:0] OFF_MODE_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h28;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_ACQ_MODE  = 7;
	localparam int BIT_PULSE_OPT = 3;
	localparam int BIT_PIN_B_FN  = 2;
	localparam int BIT_DRV_TYPE  = 1;
	localparam int BIT_POLARITY  = 0;
	localparam int BIT_SOFT_RST  = 0;
	localparam int BIT_HIBERNATE = 1;
	localparam int BIT_ST_TRIG   = 0;
	localparam int BIT_ST_DONE   = 1;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_PIN_CONFIG = 8'h01;
	localparam logic [1:0] RST_MASK       = 2'h0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ        = 125;
	localparam int PULSE_US       = 32;
	localparam int PULSE_CYCLES   = PULSE_US * CLK_MHZ;
	localparam int ACQ_CYCLES     = 4;

	// Pin drive pair: level, drive enable (active low)
	typedef struct packed {
		logic out;
		logic oe_n;
	} ipc_pin_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACQ,
		ST_DONE
	} ipc_state_t;

endpackage

// ===== ipc_top.sv
// Interrupt pin driver, polarity and external trigger configuration block
//
// Overview of operation
// - With pin B function select 0, pin B is an interrupt output fed by routed events.
// - With pin B function select 1, a rising edge on pin B starts a measurement.
// - In full decimated trigger mode one edge runs all decimation acquisitions.
// - The mode status register shows when the external trigger input is active.
// - While trigger input is active, pin B routing is ignored and pin B is high-Z.
// - With the boot strap high the pin B function select bit is ignored.
// - Driver type 0 gives push-pull pins, 1 gives open-drain or open-source.
// - The driver type bit survives a soft reset, lost only on hibernate.
// - With the boot strap high both pin drivers are fixed open-drain.
// - Polarity 0 asserts low, idles high and gives a negative ready pulse.
// - Polarity 1, the reset value, asserts high, idles low, positive pulse.
// - The polarity bit survives a soft reset, lost only on hibernate.
// - With the boot strap high polarity is fixed active low.
// - Open-drain with polarity 0 drives 0 when asserted, else high-Z.
// - Open-source with polarity 1 drives 1 when asserted, else high-Z.
// - Pulse option 1 gives a 32 us ready pulse per data cycle, ORed in.
`timescale 1ns/1ps
`default_nettype none

module ipc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        boot_strap_select,
	input  wire logic        events_pin_a,
	input  wire logic        events_pin_b,
	input  wire logic        data_ready_event,
	input  wire logic        decimation_cycles_done,
	output logic             acquire_start,
	output logic             irq_pin_a_out,
	output logic             irq_pin_a_oe_n,
	output logic             irq_pin_b_out,
	output logic             irq_pin_b_oe_n,
	input  wire logic        irq_pin_b_in,
	output logic             irq
);

	// ****************************************************************
	// Register bus
	// ****************************************************************
	logic [7:0] cfg;
	logic [7:0] next_cfg;
	logic [1:0] next_sts;
	logic [31:0] next_prdata;
	logic [1:0] sts;
	logic [1:0] msk;
	logic       hib;
	logic       soft_rst;
	logic       wr_en;
	logic       rd_en;
	logic       map_hit;
	logic       trig_en;
	logic       trig_pulse;
	logic       acq_done;
	ipc_pkg::ipc_state_t state;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign map_hit = paddr == ipc_pkg::OFF_PIN_CONFIG
		|| paddr == ipc_pkg::OFF_EXTRA
		|| paddr == ipc_pkg::OFF_MODE_STATUS
		|| paddr == ipc_pkg::OFF_IRQ_STATUS
		|| paddr == ipc_pkg::OFF_IRQ_MASK;
	assign soft_rst = wr_en && paddr == ipc_pkg::OFF_EXTRA
		&& pwdata[ipc_pkg::BIT_SOFT_RST];

	// Answer in the setup cycle so access completes in one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	// Unmapped offsets answer with an error and read as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !map_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_en) begin
			prdata <= next_prdata;
		end
	end

	// Looked up from the setup address so data stands during access
	always_comb begin
		next_prdata = 32'h0;
		case (paddr)
		ipc_pkg::OFF_PIN_CONFIG:  next_prdata = {24'h0, cfg};
		ipc_pkg::OFF_EXTRA:       next_prdata = {30'h0, hib, 1'b0};
		ipc_pkg::OFF_MODE_STATUS: next_prdata = {31'h0, trig_en};
		ipc_pkg::OFF_IRQ_STATUS:  next_prdata = {30'h0, sts};
		ipc_pkg::OFF_IRQ_MASK:    next_prdata = {30'h0, msk};
		default:                  next_prdata = 32'h0;
		endcase
	end

	// ****************************************************************
	// Configuration register
	// ****************************************************************
	// Soft reset clears all but driver type and polarity
	always_comb begin
		next_cfg = cfg;
		if (wr_en && paddr == ipc_pkg::OFF_EXTRA
			&& pwdata[ipc_pkg::BIT_HIBERNATE]) begin
			// Hibernate loses everything, even the pin setup
			next_cfg = ipc_pkg::RST_PIN_CONFIG;
		end else if (soft_rst) begin
			next_cfg = {6'h0, cfg[ipc_pkg::BIT_DRV_TYPE],
				cfg[ipc_pkg::BIT_POLARITY]};
		end else if (wr_en && paddr == ipc_pkg::OFF_PIN_CONFIG) begin
			next_cfg = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= ipc_pkg::RST_PIN_CONFIG;
		end else begin
			cfg <= next_cfg;
		end
	end

	// Hibernate flag, left for software to clear on wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hib <= 1'b0;
		end else if (wr_en && paddr == ipc_pkg::OFF_EXTRA) begin
			hib <= pwdata[ipc_pkg::BIT_HIBERNATE];
		end
	end

	// ****************************************************************
	// Effective settings after strap override
	// ****************************************************************
	logic eff_od;
	logic eff_pol;
	assign trig_en = cfg[ipc_pkg::BIT_PIN_B_FN]
		&& !boot_strap_select;
	assign eff_od  = boot_strap_select
		|| cfg[ipc_pkg::BIT_DRV_TYPE];
	assign eff_pol = !boot_strap_select
		&& cfg[ipc_pkg::BIT_POLARITY];

	// ****************************************************************
	// Trigger edge detection
	// ****************************************************************
	logic [2:0] trig_sync;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_sync <= 3'h0;
		end else begin
			trig_sync <= {trig_sync[1:0], irq_pin_b_in};
		end
	end
	// Only stages two and three compared; stage one is metastable
	assign trig_pulse = trig_en && trig_sync[1]
		&& !trig_sync[2];

	// ****************************************************************
	// Acquisition sequencer
	// ****************************************************************
	// Full mode holds one request until all decimation acquisitions end;
	// edges seen outside idle are dropped, a sequence never restarts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ipc_pkg::ST_IDLE;
		end else begin
			case (state)
			ipc_pkg::ST_IDLE: begin
				if (trig_pulse && cfg[ipc_pkg::BIT_ACQ_MODE]) begin
					state <= ipc_pkg::ST_ACQ;
				end else if (trig_pulse) begin
					state <= ipc_pkg::ST_DONE;
				end
			end
			ipc_pkg::ST_ACQ: begin
				if (decimation_cycles_done) begin
					state <= ipc_pkg::ST_DONE;
				end
			end
			ipc_pkg::ST_DONE: state <= ipc_pkg::ST_IDLE;
			default:          state <= ipc_pkg::ST_IDLE;
			endcase
		end
	end

	// One request per single edge, a held request in full mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acquire_start <= 1'b0;
		end else begin
			case (state)
			ipc_pkg::ST_IDLE: acquire_start <= trig_pulse;
			ipc_pkg::ST_ACQ:  acquire_start <= !decimation_cycles_done;
			default:          acquire_start <= 1'b0;
			endcase
		end
	end
	assign acq_done = state == ipc_pkg::ST_DONE;

	// ****************************************************************
	// Ready pulse
	// ****************************************************************
	localparam logic [11:0] PULSE_LAST = 12'(ipc_pkg::PULSE_CYCLES - 1);
	logic [11:0] pulse_cnt;
	logic        pulse_on;
	logic        ready_start;
	// The option has no effect while the strap is high
	assign ready_start = data_ready_event && cfg[ipc_pkg::BIT_PULSE_OPT]
		&& !boot_strap_select;

	// A new data cycle restarts the pulse rather than stretching it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_cnt <= 12'h0;
		end else if (ready_start) begin
			pulse_cnt <= 12'h0;
		end else if (pulse_on) begin
			pulse_cnt <= pulse_cnt + 12'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_on <= 1'b0;
		end else if (ready_start) begin
			pulse_on <= 1'b1;
		end else if (pulse_on) begin
			pulse_on <= pulse_cnt != PULSE_LAST;
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	logic       act_a;
	logic       act_b;
	logic       next_a_out;
	logic       next_a_oe_n;
	logic       next_b_out;
	logic       next_b_oe_n;
	assign act_a = events_pin_a || pulse_on;
	assign act_b = events_pin_b || pulse_on;

	// Push-pull drives both levels; open types float when idle
	always_comb begin
		next_a_out  = act_a ? eff_pol : !eff_pol;
		next_a_oe_n = eff_od && !act_a;
	end

	// Pin B becomes a floating input while it takes trigger edges
	always_comb begin
		next_b_out  = act_b ? eff_pol : !eff_pol;
		next_b_oe_n = eff_od && !act_b;
		if (trig_en) begin
			next_b_out  = 1'b0;
			next_b_oe_n = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin_a_out  <= 1'b0;
			irq_pin_a_oe_n <= 1'b1;
		end else begin
			irq_pin_a_out  <= next_a_out;
			irq_pin_a_oe_n <= next_a_oe_n;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin_b_out  <= 1'b0;
			irq_pin_b_oe_n <= 1'b1;
		end else begin
			irq_pin_b_out  <= next_b_out;
			irq_pin_b_oe_n <= next_b_oe_n;
		end
	end

	// ****************************************************************
	// Interrupt status and mask
	// ****************************************************************
	// Hardware set wins over a same-cycle write-one clear
	always_comb begin
		next_sts = sts;
		if (wr_en && paddr == ipc_pkg::OFF_IRQ_STATUS) begin
			next_sts = sts & ~pwdata[1:0];
		end
		next_sts = next_sts | {acq_done, trig_pulse};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sts <= 2'h0;
		end else begin
			sts <= next_sts;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msk <= ipc_pkg::RST_MASK;
		end else if (wr_en && paddr == ipc_pkg::OFF_IRQ_MASK) begin
			msk <= pwdata[1:0];
		end
	end

	// Level output, one cycle behind the status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(sts & msk);
		end
	end

endmodule

`default_nettype wire

// ===== irq_pin_trigger_config_tb_top.sv
// Testbench: register, pin and trigger tests for the pin config block
`timescale 1ns/1ps
`default_nettype none
module irq_pin_trigger_config_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, er, strap = 0, ev_a = 0, ev_b = 0, done = 0;
	logic acq, a_out, a_oe_n, b_out, b_oe_n, pin_a, pin_b, irq;
	logic pull_up = 0, trig = 0, rdy = 0;
	int n_fail = 0, cmp_count = 0, cyc = 0, n;
	always #4 pclk = ~pclk;
	ipc_top u_ipc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .boot_strap_select(strap),
		.events_pin_a(ev_a), .events_pin_b(ev_b), .data_ready_event(rdy),
		.decimation_cycles_done(done), .acquire_start(acq),
		.irq_pin_a_out(a_out), .irq_pin_a_oe_n(a_oe_n), .irq_pin_b_out(b_out),
		.irq_pin_b_oe_n(b_oe_n), .irq_pin_b_in(pin_b), .irq);
	ipc_host u_ipc_host (.pin_a_out(a_out), .pin_a_oe_n(a_oe_n),
		.pin_b_out(b_out), .pin_b_oe_n(b_oe_n), .pull_up, .trig_level(trig),
		.pin_a, .pin_b);
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge pclk) if (++cyc == 20000) begin
		n_fail++;
		stop_test();
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
		cmp_count++;
		if (v !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", s, e, v);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 0, 0);
		chk("prdata", e, q);
	endtask
	task automatic pulse;
		n = 0;
		trig <= 1;
		repeat (12) @(posedge pclk) n += acq;
		trig <= 0;
		repeat (4) @(posedge pclk);
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rd(8'h18, 32'h01);
		rd(8'h28, 32'h00);
		apb(8'h40, 0, 0);
		chk("pslverr", 1, er);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			apb(8'h18, 1, 32'(i & 3));
			pull_up <= !i[0];
			ev_a <= i[2];
			ev_b <= i[2];
			repeat (3) @(posedge pclk);
			chk("pin_a", i[2] ? i[0] : !i[0], pin_a);
			chk("oe_n", i[1] & !i[2], a_oe_n);
			chk("pin_b_out", i[2] ? i[0] : !i[0], b_out);
			chk("b_oe_n", i[1] & !i[2], b_oe_n);
		end
		$display("test drivers done");
		apb(8'h18, 1, 32'h0e);
		apb(8'h1c, 1, 32'h01);
		rd(8'h18, 32'h02);
		apb(8'h1c, 1, 32'h02);
		rd(8'h18, 32'h01);
		$display("test soft reset done");
		apb(8'h18, 1, 32'h04);
		rd(8'h20, 32'h01);
		ev_b <= 1;
		repeat (3) @(posedge pclk);
		chk("pin_b_oe_n", 1, b_oe_n);
		pulse();
		chk("single starts", 1, n);
		apb(8'h24, 1, 32'h03);
		apb(8'h18, 1, 32'h84);
		trig <= 1;
		repeat (9) @(posedge pclk);
		chk("full held", 1, acq);
		done <= 1;
		@(posedge pclk) done <= 0;
		repeat (3) @(posedge pclk);
		chk("full end", 0, acq);
		trig <= 0;
		chk("irq masked", 0, irq);
		apb(8'h28, 1, 32'h01);
		repeat (2) @(posedge pclk);
		chk("irq", 1, irq);
		apb(8'h24, 1, 32'h03);
		repeat (2) @(posedge pclk);
		chk("irq clear", 0, irq);
		$display("test trigger done");
		ev_a <= 0;
		ev_b <= 0;
		apb(8'h18, 1, 32'h09);
		rdy <= 1;
		@(posedge pclk) rdy <= 0;
		repeat (3997) @(posedge pclk);
		chk("pulse on", 1, a_out);
		repeat (10) @(posedge pclk);
		chk("pulse off", 0, a_out);
		$display("test pulse done");
		strap <= 1;
		pull_up <= 1;
		apb(8'h18, 1, 32'h05);
		rd(8'h20, 32'h00);
		pulse();
		chk("strap starts", 0, n);
		ev_a <= 1;
		repeat (3) @(posedge pclk);
		chk("strap low", 0, pin_a);
		ev_a <= 0;
		repeat (3) @(posedge pclk);
		chk("strap idle", 1, pin_a);
		$display("test strap done");
		stop_test();
	end
endmodule
`default_nettype wire
